// ==== hw/sysctrl_irq_enable_mask.sv ====
// Purpose: interrupt-enable mask of the system controller, set/clear views
// Assumes: source flags come from logic on pclk; standard APB master
// Notes:   pready rises in the access phase; zero wait states
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sysctrl_irq_enable_mask
	import sysctrl_irq_pkg::*;
(
	// clock and reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	// apb slave
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [11:0]     paddr,
	input  wire logic [31:0]     pwdata,
	output var  logic [31:0]     prdata,
	output var  logic            pready,
	output var  logic            pslverr,
	// interrupt sources and request
	input  wire logic [EN_W-1:0] src_flags,
	output var  logic            irq
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	apb_req_t    req;
	logic [31:0] en_r;
	logic [31:0] en_nxt;
	logic [31:0] st_r;
	logic [31:0] st_nxt;
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;
	logic        irq_r;
	logic        acc;
	logic        setup;
	logic        wr_clr;
	logic        wr_set;
	logic        wr_st;
	logic [31:0] wmask;
	logic [31:0] flags32;

	function automatic logic mapped(input logic [11:0] a);
		return (a == OFF_EN_CLEAR) || (a == OFF_EN_SET) || (a == OFF_STATUS);
	endfunction

	assign req.sel    = psel;
	assign req.enable = penable;
	assign req.write  = pwrite;
	assign req.addr   = paddr;
	assign req.wdata  = pwdata;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	assign setup   = req.sel && !req.enable;
	assign acc     = req.sel && req.enable && pready_r && !pslverr_r;
	assign wmask   = req.wdata & EN_IMPL;
	assign wr_clr  = acc && req.write && (req.addr == OFF_EN_CLEAR);
	assign wr_set  = acc && req.write && (req.addr == OFF_EN_SET);
	assign wr_st   = acc && req.write && (req.addr == OFF_STATUS);
	assign flags32 = {{(32-EN_W){1'b0}}, src_flags} & EN_IMPL;

	// ----------------------------------------
	// enable mask
	// ----------------------------------------
	always_comb begin
		en_nxt = en_r;
		if (wr_clr) begin
			en_nxt = en_r & ~wmask;
		end
		if (wr_set) begin
			en_nxt = en_r | wmask;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_r <= EN_RESET;
		end else begin
			en_r <= en_nxt;
		end
	end

	// ----------------------------------------
	// sticky status, write one to clear
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		if (wr_st) begin
			st_nxt = st_nxt & ~wmask;
		end
		// set wins over a clear in the same cycle
		st_nxt = st_nxt | flags32;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= ST_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// interrupt request
	// ----------------------------------------
	// gate flags by enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(st_nxt & en_nxt);
		end
	end

	// ----------------------------------------
	// apb answer
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= setup;
			pslverr_r <= setup && !mapped(req.addr);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup && !req.write) begin
			unique case (req.addr)
				OFF_EN_CLEAR, OFF_EN_SET: begin
					prdata_r <= en_r & EN_IMPL;
				end
				OFF_STATUS: begin
					prdata_r <= st_r & EN_IMPL;
				end
				default: begin
					prdata_r <= 32'h0000_0000;
				end
			endcase
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign irq     = irq_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// ref stop clear
	ref_stop_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_clr && pwdata[B_FLL_REF_STOP] |=> !en_r[B_FLL_REF_STOP])
		else $error("ref stop enable not cleared");

	coarse_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_clr && pwdata[B_FLL_COARSE] |=> !en_r[B_FLL_COARSE])
		else $error("coarse lock enable not cleared");

	fine_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_clr && pwdata[B_FLL_FINE] |=> !en_r[B_FLL_FINE])
		else $error("fine lock enable not cleared");

	oob_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_clr && pwdata[B_FLL_OOB] |=> !en_r[B_FLL_OOB])
		else $error("out of bounds enable not cleared");

	fll_rdy_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_clr && pwdata[B_FLL_RDY] |=> !en_r[B_FLL_RDY])
		else $error("loop ready enable not cleared");

	rc8_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_clr && pwdata[B_RC_8M_RDY] |=> !en_r[B_RC_8M_RDY])
		else $error("rc 8 MHz enable not cleared");

	rc32_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_clr && pwdata[B_RC_32K_RDY] |=> !en_r[B_RC_32K_RDY])
		else $error("rc 32 kHz enable not cleared");

	xtal32_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_clr && pwdata[B_CRYSTAL_32K_RDY] |=> !en_r[B_CRYSTAL_32K_RDY])
		else $error("crystal 32 kHz enable not cleared");

	xtal_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_clr && pwdata[B_CRYSTAL_OSC_RDY] |=> !en_r[B_CRYSTAL_OSC_RDY])
		else $error("crystal enable not cleared");

	zero_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_clr || wr_set) |=> ((en_r ^ $past(en_r)) & ~$past(pwdata)) == 32'h0000_0000)
		else $error("zero write changed an enable");

	irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		irq == |(st_r & en_r & EN_IMPL))
		else $error("request does not match enabled flags");

	no_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		(en_r == 32'h0000_0000) && !wr_set |=> !irq)
		else $error("request with all sources disabled");

	reset_zero_a: assert property (@(posedge pclk)
		!presetn |=> (en_r == EN_RESET) || !presetn)
		else $error("enables not zero after reset");

	lto_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_set && pwdata[B_PLL_LOCK_TIMEOUT] |=> en_r[B_PLL_LOCK_TIMEOUT])
		else $error("lock time-out enable not set");

	pll_bod_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_clr |=> (en_r & $past(pwdata) & 32'h0003_8e00) == 32'h0000_0000)
		else $error("pll or brown-out enable not cleared");

	others_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_set |=> (~en_r & $past(pwdata) & EN_IMPL) == 32'h0000_0000)
		else $error("set write missed an enable");

	read_view_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && (paddr == OFF_EN_CLEAR || paddr == OFF_EN_SET)
		|=> prdata == $past(en_r))
		else $error("enable view read mismatch");

	reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		((en_r | prdata) & ~EN_IMPL) == 32'h0000_0000)
		else $error("reserved bit nonzero");

	ready_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup |=> pready ##1 !pready)
		else $error("pready not one cycle after setup");

	clr_no_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_clr |=> (en_r & ~$past(en_r)) == 32'h0000_0000)
		else $error("clear write set an enable");

	set_no_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_set |=> (~en_r & $past(en_r)) == 32'h0000_0000)
		else $error("set write cleared an enable");

	en_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_clr || wr_set) |=> en_r == $past(en_r))
		else $error("enable changed without a write");

	status_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		!wr_st |=> ($past(st_r) & ~st_r) == 32'h0000_0000)
		else $error("status bit dropped without a clear");

	flag_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
		presetn && (flags32 != 32'h0000_0000) |=> (st_r & $past(flags32)) == $past(flags32))
		else $error("source flag did not set status");

	reset_quiet_a: assert property (@(posedge pclk)
		!presetn |=> (!irq && !pready && !pslverr && prdata == 32'h0000_0000) || !presetn)
		else $error("outputs active after reset");

	lock_rise_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_set && pwdata[B_PLL_LOCK_RISE] |=> en_r[B_PLL_LOCK_RISE])
		else $error("lock rise enable not set");

	lock_fall_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_set && pwdata[B_PLL_LOCK_FALL] |=> en_r[B_PLL_LOCK_FALL])
		else $error("lock fall enable not set");

	brownout_det_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_set && pwdata[B_BOD_DET] |=> en_r[B_BOD_DET])
		else $error("brown-out detect enable not set");

	brownout_rdy_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_set && pwdata[B_BOD_RDY] |=> en_r[B_BOD_RDY])
		else $error("brown-out ready enable not set");

	sync_rdy_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_set && pwdata[B_BOD_SYNC_RDY] |=> en_r[B_BOD_SYNC_RDY])
		else $error("sync ready enable not set");

	rc8_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_set && pwdata[B_RC_8M_RDY] |=> en_r[B_RC_8M_RDY])
		else $error("rc 8 MHz enable not set");

endmodule // sysctrl_irq_enable_mask
`default_nettype wire

// ==== hw/sysctrl_irq_pkg.sv ====
// Purpose: shared constants and types of the interrupt-enable mask block
// Assumes: 32-bit APB, one aligned word per register
// Notes:   enable layout is common to the set and clear views
`default_nettype none
package sysctrl_irq_pkg;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] OFF_EN_CLEAR = 12'h000;
	localparam logic [11:0] OFF_EN_SET   = 12'h004;
	localparam logic [11:0] OFF_STATUS   = 12'h008;

	localparam int          EN_W         = 18;
	localparam logic [31:0] EN_RESET     = 32'h0000_0000;
	localparam logic [31:0] ST_RESET     = 32'h0000_0000;
	// implemented bits: 17..15 and 11..0
	localparam logic [31:0] EN_IMPL      = 32'h0003_8fff;

	// ----------------------------------------
	// bit positions of the enable layout
	// ----------------------------------------
	localparam int B_CRYSTAL_OSC_RDY  = 0;
	localparam int B_CRYSTAL_32K_RDY  = 1;
	localparam int B_RC_32K_RDY       = 2;
	localparam int B_RC_8M_RDY        = 3;
	localparam int B_FLL_RDY          = 4;
	localparam int B_FLL_OOB          = 5;
	localparam int B_FLL_FINE         = 6;
	localparam int B_FLL_COARSE       = 7;
	localparam int B_FLL_REF_STOP     = 8;
	localparam int B_BOD_RDY          = 9;
	localparam int B_BOD_DET          = 10;
	localparam int B_BOD_SYNC_RDY     = 11;
	localparam int B_PLL_LOCK_RISE    = 15;
	localparam int B_PLL_LOCK_FALL    = 16;
	localparam int B_PLL_LOCK_TIMEOUT = 17;

	// ----------------------------------------
	// apb request bundle
	// ----------------------------------------
	typedef struct packed {
		logic        sel;
		logic        enable;
		logic        write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} apb_req_t;

endpackage
`default_nettype wire

// ==== sim/sysctrl_irq_enable_mask_tb.sv ====
// Purpose: self-checking bench for the interrupt-enable mask block
// Assumes: zero-wait APB slave, status view at OFF_STATUS
// Notes:   all stimulus after the time-0 initial values is driven by non-blocking assignment at pclk rise
`timescale 1ns/10ps
`default_nettype none
module sysctrl_irq_enable_mask_tb;
	import sysctrl_irq_pkg::*;

	logic            pclk;
	logic            presetn;
	logic            psel;
	logic            penable;
	logic            pwrite;
	logic [11:0]     paddr;
	logic [31:0]     pwdata;
	logic [31:0]     prdata;
	logic            pready;
	logic            pslverr;
	logic [EN_W-1:0] src_flags;
	logic            irq;
	logic [31:0]     rd;
	logic            er;
	int              num_errors;
	int              n_tests;
	int              cyc = 0;

	sysctrl_irq_enable_mask dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_flags(src_flags), .irq(irq));

	// ----------------------------------------
	// clock, timeout and closing report
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			$display("MISMATCH t=%0t timeout got=%h exp=%h", $time, cyc, 32'h0000_4e1f);
			finish_test();
		end
	end

	// ----------------------------------------
	// bus cycle and compare
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// wait for the answer; only the bench timeout ends a hang
		while (pready !== 1'b1) begin
			@(posedge pclk);
			n++;
		end
		// zero wait states expected
		chk(n, 32'h0);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic irqchk(input logic exp);
		@(posedge pclk);
		chk({31'h0, irq}, {31'h0, exp});
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] m;
		num_errors = 0;
		n_tests = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		src_flags = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;

		rdchk(OFF_EN_SET, EN_RESET);
		rdchk(OFF_EN_CLEAR, EN_RESET);
		$display("test reset values done");

		apb(1'b1, OFF_EN_SET, 32'hffff_ffff);
		rdchk(OFF_EN_SET, EN_IMPL);
		rdchk(OFF_EN_CLEAR, EN_IMPL);
		apb(1'b1, OFF_EN_SET, 32'h0);
		apb(1'b1, OFF_EN_CLEAR, 32'h0);
		rdchk(OFF_EN_SET, EN_IMPL);
		for (int b = 0; b < 32; b++) begin
			m = EN_IMPL & ~(32'h1 << b);
			apb(1'b1, OFF_EN_CLEAR, 32'h1 << b);
			rdchk(OFF_EN_CLEAR, m);
			apb(1'b1, OFF_EN_SET, 32'h1 << b);
			rdchk(OFF_EN_SET, EN_IMPL);
		end
		$display("test set and clear per bit done");

		apb(1'b1, OFF_EN_CLEAR, 32'hffff_ffff);
		apb(1'b1, OFF_STATUS, 32'hffff_ffff);
		for (int b = 0; b < EN_W; b++) begin
			if (EN_IMPL[b]) begin
				@(posedge pclk);
				src_flags <= EN_W'(1) << b;
				@(posedge pclk);
				src_flags <= '0;
				irqchk(1'b0);
				rdchk(OFF_STATUS, 32'h1 << b);
				apb(1'b1, OFF_EN_SET, 32'h1 << b);
				irqchk(1'b1);
				apb(1'b1, OFF_EN_CLEAR, 32'h1 << b);
				irqchk(1'b0);
				apb(1'b1, OFF_STATUS, 32'h1 << b);
			end
		end
		$display("test interrupt masking done");

		// flag arriving while its source is already enabled
		apb(1'b1, OFF_EN_SET, 32'h1 << B_BOD_DET);
		@(posedge pclk);
		src_flags <= EN_W'(1) << B_BOD_DET;
		@(posedge pclk);
		src_flags <= '0;
		irqchk(1'b1);
		apb(1'b1, OFF_STATUS, 32'h1 << B_BOD_DET);
		irqchk(1'b0);
		apb(1'b1, OFF_EN_CLEAR, 32'h1 << B_BOD_DET);
		$display("test enabled source request done");

		apb(1'b1, 12'h010, 32'hffff_ffff);
		chk({31'h0, er}, 32'h1);
		rdchk(OFF_EN_SET, 32'h0);
		apb(1'b0, 12'h00c, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		$display("test unmapped access done");

		apb(1'b1, OFF_EN_SET, 32'hffff_ffff);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(OFF_EN_SET, EN_RESET);
		rdchk(OFF_EN_CLEAR, EN_RESET);
		$display("test mid-run reset done");
		finish_test();
	end

endmodule // sysctrl_irq_enable_mask_tb
`default_nettype wire
